//--- rtl/csd_pkg.sv
// chip-select decoder package: register indices, field layout, resets,
// and the carrier structs for bus, cpu address and select pins.
// assumes one 40 MHz clock (25 ns) and an ahb-lite master with 32-bit data.
package csd_pkg;
    // --------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [29:0] CSD_IDX_STRH = 30'h0000105c; // stretch select
    localparam logic [29:0] CSD_IDX_CTL  = 30'h0000105d; // chip_select_control
    localparam logic [29:0] CSD_IDX_GADR = 30'h0000105e; // general_select_base
    localparam logic [29:0] CSD_IDX_GSZ  = 30'h0000105f; // general_size_control

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CSD_CTL_IO1_EN  = 7; // io_select_one_enable
    localparam int CSD_CTL_IO1_POL = 6; // io_select_one_polarity
    localparam int CSD_CTL_IO2_EN  = 5; // io_select_two_enable
    localparam int CSD_CTL_IO2_POL = 4; // io_select_two_polarity
    localparam int CSD_CTL_PRIO    = 3; // general_over_program_priority
    localparam int CSD_CTL_PROG_EN = 2; // program_select_enable
    localparam int CSD_GSZ_IO1AV = 7; // io one on address-valid time
    localparam int CSD_GSZ_IO2AV = 6; // io two on address-valid time
    localparam int CSD_GSZ_GNPOL = 4; // general select polarity
    localparam int CSD_GSZ_GAVLD = 3; // general select on address-valid time

    // --------------------------------------------------------------
    // masks, resets and fixed ranges
    // --------------------------------------------------------------
    localparam logic [7:0]  CSD_GADR_MASK = 8'hfc; // low two bits absent
    localparam logic [7:0]  CSD_GSZ_MASK  = 8'hdf; // bit 5 reserved
    localparam logic [7:0]  CSD_RST_CTL   = 8'h00; // enable bit patched
    localparam logic [7:0]  CSD_RST_GADR  = 8'h00;
    localparam logic [7:0]  CSD_RST_GSZ   = 8'h07; // general select off
    localparam logic [7:0]  CSD_RST_STRH  = 8'h00;
    localparam logic [1:0]  CSD_PSTH_EXP  = 2'h1; // program stretch, expanded
    localparam logic [2:0]  CSD_GSIZE_OFF = 3'h7; // size code for 0 K
    localparam logic [11:0] CSD_IO1_LO    = 12'h060; // io one page start
    localparam logic [31:0] CSD_HRDATA_RST = 32'h00000000;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } csd_ahb_in_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } csd_ahb_out_t;

    typedef struct packed {
        logic [15:0] addr;       // cpu address of the current bus cycle
        logic        addr_valid; // address-valid portion of the cycle
        logic        e_high;     // e-clock valid portion of the cycle
    } csd_cpu_t;

    typedef struct packed {
        logic       cs_prog_n;   // program_select, always active low
        logic       cs_io1;      // io_select_one, programmable level
        logic       cs_io2;      // io_select_two, programmable level
        logic       cs_gen;      // general_select, programmable level
        logic       pg7_own;     // port g pin 7 taken by program_select
        logic       pg5_own;     // port g pin 5 taken by io_select_one
        logic       pg4_own;     // port g pin 4 taken by io_select_two
        logic       gen_own;     // general_select pin in use
        logic [1:0] stretch;     // e-cycle stretch for the asserted select
    } csd_pins_t;

    localparam csd_pins_t CSD_PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1,
                                          1'b0, 1'b0, 1'b0, 1'b0, 2'h0};
endpackage : csd_pkg

//--- rtl/csd_top.sv
// chip-select decoder: four address-decoded selects for the expansion bus,
// configured over an ahb-lite slave port.
// assumes cpu_i, mode_expanded and reg_base_nibble are synchronous to clk.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// R1: io one enable gives port g pin 5
// R2: io one polarity bit: 0 low, 1 high
// R3: io two enable gives port g pin 4
// R4: io two polarity bit: 0 low, 1 high
// R5: priority bit picks program or general winner
// R6: program enable resets to expanded strap, others 0
// R7: program enable gives port g pin 7
// R8: program size field sets top-aligned range
// R9: base bits compare with address 15:10
// R10: only bits above size are compared
// R11: io selects split the register page
// R12: program select low, address-valid time only
// R13: asserted select picks its stretch count
// R14: general select never asserts at size zero
// R15: program/general overlap asserts only the winning select
// R16: base register low two bits read zero
module csd_top (
    // clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // straps and page base
    input  wire logic                  mode_expanded,
    input  wire logic [3:0]            reg_base_nibble,
    // register bus
    input  wire csd_pkg::csd_ahb_in_t  ahb_i,
    output      csd_pkg::csd_ahb_out_t ahb_o,
    // cpu bus cycle
    input  wire csd_pkg::csd_cpu_t     cpu_i,
    // select pins
    output      csd_pkg::csd_pins_t    pins_o
);
    import csd_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  strh;    // select_stretch_control
        logic [7:0]  ctl;     // chip_select_control
        logic [7:0]  gadr;    // general_select_base
        logic [7:0]  gsz;     // general_size_control
        logic        wr_pend; // write data phase follows
        logic [29:0] waddr;   // word index of the pending write
        logic        rdy;     // hreadyout
        logic [31:0] rdata;   // hrdata
        csd_pins_t   pins;    // registered select pins
    } csd_state_t;

    csd_state_t s_q;          // registered state
    csd_state_t s_d;          // next state

    logic       take;         // address phase accepted
    logic [7:0] rd;           // read mux value
    logic       tv_io1;       // io one timing window
    logic       tv_io2;       // io two timing window
    logic       tv_gen;       // general timing window
    logic       in_page;      // address inside the register page
    logic       hit_io1;      // io one range hit
    logic       hit_io2;      // io two range hit
    logic       hit_prog;     // program range hit
    logic       hit_gen;      // general range hit
    logic [5:0] gmask;        // compared base bits
    logic       act_io1;      // io one asserted
    logic       act_io2;      // io two asserted
    logic       act_prog;     // program asserted
    logic       act_gen;      // general asserted

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // write data phase: hwdata stands now, low byte carries the value
        if (s_q.wr_pend) begin
            if (s_q.waddr == CSD_IDX_STRH) begin
                s_d.strh = ahb_i.hwdata[7:0];
            end else if (s_q.waddr == CSD_IDX_CTL) begin
                s_d.ctl = ahb_i.hwdata[7:0];
            end else if (s_q.waddr == CSD_IDX_GADR) begin
                s_d.gadr = ahb_i.hwdata[7:0] & CSD_GADR_MASK; // R16
            end else if (s_q.waddr == CSD_IDX_GSZ) begin
                s_d.gsz = ahb_i.hwdata[7:0] & CSD_GSZ_MASK;
            end
        end
        // address phase; zero wait states, so hready is always high
        take       = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
        s_d.wr_pend = take && ahb_i.hwrite;
        s_d.waddr   = ahb_i.haddr[31:2];
        s_d.rdy     = 1'b1;
        // reads sample the next state so a write just ahead is seen
        if (ahb_i.haddr[31:2] == CSD_IDX_STRH) begin
            rd = s_d.strh;
        end else if (ahb_i.haddr[31:2] == CSD_IDX_CTL) begin
            rd = s_d.ctl;
        end else if (ahb_i.haddr[31:2] == CSD_IDX_GADR) begin
            rd = s_d.gadr; // R16
        end else if (ahb_i.haddr[31:2] == CSD_IDX_GSZ) begin
            rd = s_d.gsz;
        end else begin
            rd = 8'h00; // unmapped reads zero
        end
        if (take && !ahb_i.hwrite) begin
            s_d.rdata = {24'h000000, rd};
        end

        // timing windows: address-valid, or e-high inside it
        tv_io1 = cpu_i.addr_valid
                 && (s_q.gsz[CSD_GSZ_IO1AV] || cpu_i.e_high);
        tv_io2 = cpu_i.addr_valid
                 && (s_q.gsz[CSD_GSZ_IO2AV] || cpu_i.e_high);
        tv_gen = cpu_i.addr_valid
                 && (s_q.gsz[CSD_GSZ_GAVLD] || cpu_i.e_high);

        // io selects fill the page that holds the register block
        in_page = cpu_i.addr[15:12] == reg_base_nibble;            // R11
        hit_io1 = in_page && !cpu_i.addr[11]
                  && (cpu_i.addr[11:0] >= CSD_IO1_LO);             // R11
        hit_io2 = in_page && cpu_i.addr[11];                       // R11

        // program range always ends at the top of the space
        case (s_q.ctl[1:0])                                        // R8
            2'h0:    hit_prog = 1'b1;
            2'h1:    hit_prog = cpu_i.addr[15];
            2'h2:    hit_prog = &cpu_i.addr[15:14];
            default: hit_prog = &cpu_i.addr[15:13];
        endcase

        // size code n compares the top n base bits; 7 is disabled
        gmask   = ~(6'h3f >> s_q.gsz[2:0]);                        // R10
        hit_gen = (s_q.gsz[2:0] != CSD_GSIZE_OFF)                  // R14
                  && (((cpu_i.addr[15:10] ^ s_q.gadr[7:2]) & gmask)
                      == 6'h00);                                   // R9

        // program/general overlap: the priority bit decides, the loser stays idle
        act_io1  = s_q.ctl[CSD_CTL_IO1_EN] && hit_io1 && tv_io1;
        act_io2  = s_q.ctl[CSD_CTL_IO2_EN] && hit_io2 && tv_io2;
        act_gen  = hit_gen && tv_gen;
        act_prog = s_q.ctl[CSD_CTL_PROG_EN] && hit_prog
                   && cpu_i.addr_valid                             // R12
                   && !(act_gen && s_q.ctl[CSD_CTL_PRIO]);         // R5 R15
        act_gen  = act_gen && !(s_q.ctl[CSD_CTL_PROG_EN] && hit_prog
                   && cpu_i.addr_valid && !s_q.ctl[CSD_CTL_PRIO]); // R5 R15

        // pin levels: polarity 0 gives active low
        s_d.pins.cs_prog_n = !act_prog;                            // R12
        s_d.pins.cs_io1    = act_io1 == s_q.ctl[CSD_CTL_IO1_POL];  // R2
        s_d.pins.cs_io2    = act_io2 == s_q.ctl[CSD_CTL_IO2_POL];  // R4
        s_d.pins.cs_gen    = act_gen == s_q.gsz[CSD_GSZ_GNPOL];
        s_d.pins.pg7_own   = s_q.ctl[CSD_CTL_PROG_EN];             // R7
        s_d.pins.pg5_own   = s_q.ctl[CSD_CTL_IO1_EN];              // R1
        s_d.pins.pg4_own   = s_q.ctl[CSD_CTL_IO2_EN];              // R3
        s_d.pins.gen_own   = s_q.gsz[2:0] != CSD_GSIZE_OFF;

        // stretch of the asserted select; io wins if ranges cross
        if (act_io1) begin                                         // R13
            s_d.pins.stretch = s_q.strh[7:6];
        end else if (act_io2) begin
            s_d.pins.stretch = s_q.strh[5:4];
        end else if (act_gen) begin
            s_d.pins.stretch = s_q.strh[3:2];
        end else if (act_prog) begin
            s_d.pins.stretch = s_q.strh[1:0];
        end else begin
            s_d.pins.stretch = 2'h0;
        end
    end

    // --------------------------------------------------------------
    // registers: reset wins over the clock enable
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.strh    <= {CSD_RST_STRH[7:2],
                            mode_expanded ? CSD_PSTH_EXP : 2'h0};
            s_q.ctl     <= CSD_RST_CTL | {5'h00, mode_expanded, 2'h0}; // R6
            s_q.gadr    <= CSD_RST_GADR;
            s_q.gsz     <= CSD_RST_GSZ;
            s_q.wr_pend <= 1'b0;
            s_q.waddr   <= 30'h00000000;
            s_q.rdy     <= 1'b1;
            s_q.rdata   <= CSD_HRDATA_RST;
            s_q.pins    <= CSD_PINS_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign ahb_o.hreadyout = s_q.rdy;
    assign ahb_o.hresp     = 1'b0; // constant okay
    assign ahb_o.hrdata    = s_q.rdata;
    assign pins_o          = s_q.pins;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic av;  // helper: address valid this cycle
    assign av = cpu_i.addr_valid;

    a_io1_idle_pin: assert property (ce && !s_q.ctl[7] |=> // R1
        !pins_o.pg5_own && pins_o.cs_io1 == !$past(s_q.ctl[6]))
        else $error("io one moved while disabled");
    a_io1_level: assert property (ce && s_q.ctl[7] && av // R2
        && s_q.gsz[7] && in_page && cpu_i.addr[11:4] >= 8'h06
        && !cpu_i.addr[11] |=> pins_o.cs_io1 == $past(s_q.ctl[6]))
        else $error("io one wrong active level");
    a_io2_level: assert property (ce && s_q.ctl[5] && av // R4
        && s_q.gsz[6] && in_page && cpu_i.addr[11]
        |=> pins_o.cs_io2 == $past(s_q.ctl[4]) && pins_o.pg4_own)
        else $error("io two wrong active level");
    a_prog_top8k: assert property (ce && s_q.ctl[2] && av // R8
        && !s_q.ctl[3] && cpu_i.addr[15:13] == 3'h7
        |=> !pins_o.cs_prog_n && pins_o.pg7_own)
        else $error("program select missed top 8k");
    a_prog_noav: assert property (ce && !av |=> // R12
        pins_o.cs_prog_n)
        else $error("program select outside address valid");
    a_prog_yields: assert property (ce && s_q.ctl[3] && av // R15
        && s_q.gsz[3:0] == 4'h8
        |=> pins_o.cs_prog_n && pins_o.cs_gen == $past(s_q.gsz[4]))
        else $error("program select did not yield");
    a_gen_yields: assert property (ce && !s_q.ctl[3] && av // R5
        && s_q.ctl[2] && s_q.ctl[1:0] == 2'h0
        |=> pins_o.cs_gen == !$past(s_q.gsz[4]) && !pins_o.cs_prog_n)
        else $error("general select did not yield");
    a_gen_off: assert property (ce && s_q.gsz[2:0] == 3'h7 // R14
        |=> pins_o.cs_gen == !$past(s_q.gsz[4]) && !pins_o.gen_own)
        else $error("general select asserted at size zero");
    a_gen_base: assert property (ce && s_q.gsz[2:0] == 3'h6 // R10
        && cpu_i.addr[15:10] != s_q.gadr[7:2]
        |=> pins_o.cs_gen == !$past(s_q.gsz[4]))
        else $error("general select ignored base bits");
    a_gadr_low: assert property (s_q.gadr[1:0] == 2'h0) // R16
        else $error("base register low bits set");
    a_reset_program_select_enable: assert property ($past(rst) |-> // R6
        s_q.ctl == {5'h00, $past(mode_expanded), 2'h0})
        else $error("control register reset value wrong");
    a_unmapped_rd: assert property (ce && take && !ahb_i.hwrite
        && ahb_i.haddr[31:4] != 28'h0000417 |=> ahb_o.hrdata == 32'h0)
        else $error("unmapped read not zero");

    c_io1_hit:  cover property (!pins_o.cs_io1 && pins_o.pg5_own);
    c_prog_hit: cover property (!pins_o.cs_prog_n);
    c_gen_hit:  cover property (pins_o.gen_own && pins_o.cs_gen
                                == s_q.gsz[4]);
    c_read:     cover property (ce && take && !ahb_i.hwrite);
endmodule : csd_top

//--- verification/csd_dev_model.sv
// expansion-bus device model: each external device decodes its own select.
// assumes the select pins come straight from the decoder in one clock domain.
`timescale 1ns/1ps
module csd_dev_model (
    // select pins from the decoder
    input  wire csd_pkg::csd_pins_t pins,
    // strap levels of io one, io two and general devices, 1 = active high
    input  wire logic [2:0]         act_high,
    // device sees itself selected: program, io one, io two, general
    output      logic [3:0]         dev_sel
);
    import csd_pkg::*;
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // program memory is wired active low; the others follow their straps,
    // so a select at its inactive level leaves the device idle
    assign dev_sel = {~pins.cs_prog_n, pins.cs_io1 == act_high[2],
                      pins.cs_io2 == act_high[1], pins.cs_gen == act_high[0]};
endmodule : csd_dev_model

//--- verification/chip_select_decoder_tb.sv
// chip-select decoder bench: random configurations and cpu cycles against a reference.
// assumes csd_top and csd_dev_model are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module chip_select_decoder_tb;
    import csd_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic         clk = 1'b0;            // 40 MHz bus clock
    logic         rst = 1'b1;            // synchronous, active high
    logic         ce = 1'b1;             // clock enable, low freezes the decoder
    logic         mode_expanded = 1'b1;  // operating-mode strap
    logic [3:0]   nib = 4'h1;            // register page nibble
    csd_ahb_in_t  ahb_m = '0;            // master side, hready added below
    csd_cpu_t     cpu = '0;              // cpu bus cycle
    csd_ahb_out_t ahb_o;
    csd_pins_t    pins;
    logic [3:0]   dev_sel;
    logic [7:0]   cq, bq, gq, sq;        // register values the bench expects
    logic [31:0]  seed = 32'd44821;
    int           err_count = 0;
    int           samples_checked = 0;
    logic [7:0]   tc [3] = '{8'hff, 8'hf7, 8'hfc}; // overlap corners, both priorities
    logic [7:0]   tg [3] = '{8'h1b, 8'h1b, 8'h18};
    // the single slave's hreadyout is the bus's hready
    wire csd_ahb_in_t ahb_i = '{ahb_m.hsel, ahb_m.haddr, ahb_m.htrans, ahb_m.hwrite,
                                ahb_m.hsize, ahb_m.hwdata, ahb_o.hreadyout};

    always #12.5 clk = ~clk;

    // clock enable comes from the bench so that a frozen cycle is exercised
    csd_top uut (.clk(clk), .rst(rst), .ce(ce), .mode_expanded(mode_expanded),
                 .reg_base_nibble(nib), .ahb_i(ahb_i), .ahb_o(ahb_o), .cpu_i(cpu),
                 .pins_o(pins));
    csd_dev_model dev (.pins(pins), .act_high({cq[6], cq[4], gq[4]}), .dev_sel(dev_sel));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // reference decode; the loser of a program/general overlap stays inactive
    function automatic csd_pins_t exp_pins(input logic [7:0] c, b, g, s,
                                           input csd_cpu_t u, output logic [3:0] hv);
        csd_pins_t   p;
        logic [15:0] pm, gm;
        logic        ph, gh, h1, h2;
        pm = ~(16'hffff >> c[1:0]);
        gm = ~(16'hffff >> g[2:0]);
        ph = c[2] & u.addr_valid & ((u.addr & pm) == pm);
        gh = (g[2:0] != 3'h7) & u.addr_valid & (g[3] | u.e_high)
             & ((u.addr & gm) == ({b[7:2], 10'h000} & gm));
        h1 = c[7] & u.addr_valid & (g[7] | u.e_high) & (u.addr[15:12] == nib)
             & !u.addr[11] & (u.addr[10:0] >= 11'h060);
        h2 = c[5] & u.addr_valid & (g[6] | u.e_high) & (u.addr[15:12] == nib) & u.addr[11];
        if (ph && gh) begin
            if (c[3]) ph = 1'b0;
            else gh = 1'b0;
        end
        p.cs_prog_n = ~ph;
        p.cs_io1 = ~(h1 ^ c[6]);
        p.cs_io2 = ~(h2 ^ c[4]);
        p.cs_gen = ~(gh ^ g[4]);
        p.pg7_own = c[2];
        p.pg5_own = c[7];
        p.pg4_own = c[5];
        p.gen_own = g[2:0] != 3'h7;
        p.stretch = h1 ? s[7:6] : h2 ? s[5:4] : gh ? s[3:2] : ph ? s[1:0] : 2'h0;
        hv = {ph, h1, h2, gh};
        return p;
    endfunction : exp_pins

    // one ahb-lite single transfer; hready is sampled at each edge before moving on
    task automatic bus(input logic wr, input logic [29:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        ahb_m.hsel <= 1'b1;
        ahb_m.htrans <= 2'b10;
        ahb_m.haddr <= {idx, 2'b00};
        ahb_m.hwrite <= wr;
        ahb_m.hsize <= 3'h2;
        // no wait count is assumed: only the watchdog ends a stuck transfer
        do @(posedge clk); while (ahb_i.hready !== 1'b1);
        ahb_m.htrans <= 2'b00;
        ahb_m.hwdata <= {24'h000000, d};
        do @(posedge clk); while (ahb_i.hready !== 1'b1);
        q = ahb_o.hrdata;
    endtask : bus

    task automatic rd_chk(input logic [29:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK("register", {24'h000000, e}, q)
        `CHK("response", 1'b0, ahb_o.hresp)
    endtask : rd_chk

    task automatic samp(input csd_cpu_t u);
        csd_pins_t  e;
        logic [3:0] hv;
        e = exp_pins(cq, bq, gq, sq, u, hv);
        @(posedge clk);
        cpu <= u;
        @(posedge clk);
        #1 `CHK("pins", e, pins)
        `CHK("device select", hv, dev_sel)
    endtask : samp

    task automatic do_reset(input logic me);
        @(posedge clk);
        mode_expanded <= me;
        rst <= 1'b1;
        cpu <= '0;
        repeat (2) @(posedge clk);
        #1 `CHK("reset pins", CSD_PINS_RST, pins)
        `CHK("reset ready", 1'b1, ahb_o.hreadyout)
        `CHK("reset read data", CSD_HRDATA_RST, ahb_o.hrdata)
        @(posedge clk);
        rst <= 1'b0;
        {cq, bq, gq, sq} = {me ? 8'h04 : 8'h00, 8'h00, 8'h07, me ? 8'h01 : 8'h00};
        rd_chk(CSD_IDX_CTL, cq);
        rd_chk(CSD_IDX_GADR, 8'h00);
        samp(cpu);
    endtask : do_reset

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        csd_cpu_t    u;
        csd_pins_t   p;
        logic [3:0]  hv;
        do_reset(1'b1);
        do_reset(1'b0);
        // unmapped place: write dropped, read gives zero
        bus(1'b1, 30'h00001060, 8'hff, q);
        rd_chk(30'h00001060, 8'h00);
        for (int i = 0; i < 40; i++) begin
            r = xs();
            {cq, bq, gq, sq} = r;
            gq = gq & CSD_GSZ_MASK;
            if (i < 3) {cq, bq, gq} = {tc[i], 8'he0, tg[i]};
            bus(1'b1, CSD_IDX_CTL, cq, q);
            bus(1'b1, CSD_IDX_GADR, bq | 8'h03, q);
            bus(1'b1, CSD_IDX_GSZ, gq, q);
            bus(1'b1, CSD_IDX_STRH, sq, q);
            nib <= r[3:0] ^ r[7:4];
            rd_chk(CSD_IDX_CTL, cq);
            rd_chk(CSD_IDX_GADR, bq & CSD_GADR_MASK);
            bq = bq & CSD_GADR_MASK;
            for (int j = 0; j < 24; j++) begin
                r = xs();
                case (j % 4)
                    0: u.addr = {nib, r[11:0]};      // register page, io selects
                    1: u.addr = {3'h7, r[12:0]};     // top of memory, program range
                    2: u.addr = {bq[7:2], r[9:0]};   // general base
                    default: u.addr = r[15:0];
                endcase
                u.addr_valid = r[16] | r[17];
                u.e_high = r[18];
                samp(u);
            end
            // clock enable low: a fresh cpu cycle must leave the pins as they stand
            p = exp_pins(cq, bq, gq, sq, u, hv);
            @(posedge clk);
            ce <= 1'b0;
            cpu <= ~u;
            repeat (2) @(posedge clk);
            #1 `CHK("frozen pins", p, pins)
            @(posedge clk);
            ce <= 1'b1;
        end
        tally_and_finish();
    end

    // watchdog: the run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule : chip_select_decoder_tb
